// ==== src/cpr_defs.svh ====
// Constants for the coprocessor state-restore port: offsets, format words, timing
`ifndef CPR_DEFS_SVH
`define CPR_DEFS_SVH

// Interface register offsets, low five address bits
`define CPR_OFF_RESPONSE 5'h00
`define CPR_OFF_CONTROL 5'h02
`define CPR_OFF_SAVE 5'h04
`define CPR_OFF_RESTORE 5'h06
`define CPR_OFF_OPWORD 5'h08
`define CPR_OFF_COMMAND 5'h0A
`define CPR_OFF_RSVD_A 5'h0C
`define CPR_OFF_CONDITION 5'h0E
`define CPR_OFF_OPERAND 5'h10
`define CPR_OFF_REGSEL 5'h14
`define CPR_OFF_RSVD_B 5'h16
`define CPR_OFF_INSTPTR 5'h18
`define CPR_OFF_OPNDPTR 5'h1C

// Format word encodings
`define CPR_FMT_NULL_HI 8'h00
`define CPR_FMT_ILLEGAL 16'h0200
`define CPR_FMT_NULL 16'h0000
`define CPR_IDLE_SIZE 8'h18
`define CPR_BUSY_SIZE 8'hB4
`define CPR_VERSION 8'h1F

// Fixed read values
`define CPR_ALL_ONES 32'hFFFF_FFFF
`define CPR_LOW_ONES 16'hFFFF
`define CPR_RESP_NULL 16'h0000
`define CPR_REGSEL_VAL 16'h0000

// Internal loader takes one frame word per this many cycles (100 ns each)
`define CPR_LOAD_GAP 4'h4

// Frame storage
`define CPR_DATA_W 32
`define CPR_FIFO_DEPTH 16

`endif

// ==== src/cpr_pkg.sv ====
// Types shared by the coprocessor state-restore port modules
package cpr_pkg;
    // Bus cycle sequencer states
    typedef enum logic [1:0] {CPR_BUS_IDLE, CPR_BUS_ACCESS, CPR_BUS_ACK} cpr_bus_e;
    // Context phase of the coprocessor
    typedef enum logic [1:0] {CPR_PH_RESET, CPR_PH_IDLE, CPR_PH_LOAD} cpr_phase_e;
    // Interface register select field
    typedef logic [4:0] cpr_sel_t;
endpackage

// ==== src/cpr_fifo.sv ====
// Frame word FIFO with valid/ready on both sides and a flush
`timescale 1ns/10ps
`default_nettype none
module cpr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];  // Entry storage in flops
    logic [AW-1:0] wr_ptr_r;  // Next slot to fill
    logic [AW-1:0] rd_ptr_r;  // Oldest slot
    logic [AW:0] count_r;  // Occupancy
    logic push;
    logic pop;

    // Honest full and empty from the count
    assign in_ready_o = (count_r != (AW+1)'(DEPTH)) && !flush_i;
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i && !flush_i;

    // Storage write by index
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // Pointers and count; flush drops everything held
    always_ff @(posedge clock_i) begin
        if (rst_i || flush_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
            end
            if (push && !pop) begin
                count_r <= count_r + (AW+1)'(1);
            end else if (pop && !push) begin
                count_r <= count_r - (AW+1)'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ==== src/cpr_fmt_check.sv ====
// Restore format word checker: validity and frame length in long words
`timescale 1ns/10ps
`default_nettype none
`include "cpr_defs.svh"
module cpr_fmt_check import cpr_pkg::*; #(
    parameter logic [7:0] VERSION = `CPR_VERSION
) (
    input wire logic [15:0] fmt_i,
    output logic valid_o,
    output logic is_null_o,
    output logic [7:0] words_o
);
    logic ver_ok;  // Version byte names this device
    logic size_ok;  // Size byte is idle or busy

    // Null is any word with a zero upper byte
    assign is_null_o = (fmt_i[15:8] == `CPR_FMT_NULL_HI);
    assign ver_ok = (fmt_i[15:8] == VERSION);
    assign size_ok = (fmt_i[7:0] == `CPR_IDLE_SIZE) || (fmt_i[7:0] == `CPR_BUSY_SIZE);
    assign valid_o = is_null_o || (ver_ok && size_ok);
    // Long words after the format word: the size byte over four, one per operand access
    assign words_o = is_null_o ? 8'h00 : {2'b00, fmt_i[7:2]};
endmodule
`default_nettype wire

// ==== src/cpr_port.sv ====
// Coprocessor bus port: interface register decode and context restore handshake
// Summary of operation
// - Restore write aborts work, readies new state
// - Format word must be null/idle/busy, version
// - Restore read-back echoes word or illegal code
// - Null frame means registers at defaults
// - Register moves never report exceptions
// - Low five address bits pick register
// - Word registers on upper half, 16-bit ack; register select here gets a 32-bit ack
// - Unused slots ignore writes, read ones
`timescale 1ns/10ps
`default_nettype none
`include "cpr_defs.svh"
module cpr_port import cpr_pkg::*; #(
    parameter logic [7:0] VERSION = `CPR_VERSION,
    parameter int FIFO_DEPTH = `CPR_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic rw_i,
    input wire logic [4:0] addr_i,
    input wire logic [31:0] data_i,
    output logic [31:0] data_o,
    output logic data_oe_o,
    output logic size_ack_high_n_o,
    output logic size_ack_low_n_o,
    output logic null_state_o,
    output logic restore_busy_o,
    output logic [7:0] frame_words_o
);
    // Pin synchronisers, two stages each; only stage two is read
    logic [38:0] pin_s1_r;
    logic [38:0] pin_s2_r;
    logic cs_act;  // Chip select, active high, synchronised
    logic rd;  // Read cycle
    cpr_sel_t sel;  // Register select field
    logic [31:0] wdata;  // Written data

    // Sequencer and context state
    cpr_bus_e bus_r;
    cpr_phase_e phase_r;
    logic [15:0] restore_r;  // Read-back value of the restore register
    logic [7:0] expected_r;  // Frame long words owed in total by the format word
    logic [7:0] pushed_r;  // Long words taken from the host
    logic [7:0] loaded_r;  // Long words consumed by the loader
    logic [3:0] gap_r;  // Loader pacing counter
    logic [31:0] data_r;
    logic data_oe_r;
    logic ack_hi_n_r;
    logic ack_lo_n_r;

    // Decode and side-effect strobes
    logic is_long;  // 32-bit register slot
    logic push_want;  // Operand write carrying a frame word
    logic acc_fire;  // Access completes this cycle
    logic wr_restore;
    logic abort;
    logic [31:0] rd_data;
    logic fmt_valid;
    logic fmt_null;
    logic [7:0] fmt_words;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;

    // Two-flop capture of all bus pins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pin_s1_r <= {1'b1, 38'h0};
            pin_s2_r <= {1'b1, 38'h0};
        end else begin
            pin_s1_r <= {cs_n_i, rw_i, addr_i, data_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign cs_act = !pin_s2_r[38];
    assign rd = pin_s2_r[37];
    assign sel = pin_s2_r[36:32];
    assign wdata = pin_s2_r[31:0];

    // Validity check of the incoming format word (upper data half)
    cpr_fmt_check #(
        .VERSION(VERSION)
    ) u_fmt (
        .fmt_i(wdata[31:16]),
        .valid_o(fmt_valid),
        .is_null_o(fmt_null),
        .words_o(fmt_words)
    );

    // Long slots: operand and the two pointers, plus register select
    assign is_long = (sel[4:2] == `CPR_OFF_OPERAND >> 2) || (sel[4:2] == `CPR_OFF_INSTPTR >> 2)
        || (sel[4:2] == `CPR_OFF_OPNDPTR >> 2) || (sel[4:1] == `CPR_OFF_REGSEL >> 1);
    // Frame words are only queued while a restore is open and owed words remain
    assign push_want = (bus_r == CPR_BUS_ACCESS) && !rd && (sel[4:2] == `CPR_OFF_OPERAND >> 2)
        && (phase_r == CPR_PH_LOAD) && (pushed_r != expected_r);
    // Back-pressure: a full FIFO holds the bus cycle unacknowledged
    assign acc_fire = (bus_r == CPR_BUS_ACCESS) && (!push_want || fifo_in_ready);
    // Low address bits select the restore slot
    assign wr_restore = acc_fire && !rd && (sel[4:1] == `CPR_OFF_RESTORE >> 1);
    // Restore or control write abandons work
    assign abort = wr_restore || (acc_fire && !rd && (sel[4:1] == `CPR_OFF_CONTROL >> 1));

    // Read data mux by select field
    always_comb begin
        rd_data = `CPR_ALL_ONES;
        if (sel[4:1] == `CPR_OFF_RESPONSE >> 1) begin
            rd_data = {`CPR_RESP_NULL, `CPR_LOW_ONES};
        end else if (sel[4:1] == `CPR_OFF_SAVE >> 1) begin
            // Save word follows the context phase
            if (phase_r == CPR_PH_RESET) begin
                rd_data = {`CPR_FMT_NULL, `CPR_LOW_ONES};
            end else if (phase_r == CPR_PH_IDLE) begin
                rd_data = {VERSION, `CPR_IDLE_SIZE, `CPR_LOW_ONES};
            end else begin
                rd_data = {`CPR_FMT_ILLEGAL, `CPR_LOW_ONES};
            end
        end else if (sel[4:1] == `CPR_OFF_RESTORE >> 1) begin
            // Echo of the checked format word
            rd_data = {restore_r, `CPR_LOW_ONES};
        end else if (sel[4:1] == `CPR_OFF_REGSEL >> 1) begin
            rd_data = {`CPR_REGSEL_VAL, `CPR_LOW_ONES};
        end else begin
            // Unused and write-only slots read ones
            rd_data = `CPR_ALL_ONES;
        end
    end

    // Bus cycle sequencer: wait select, act once, hold ack until release
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            bus_r <= CPR_BUS_IDLE;
        end else begin
            case (bus_r)
                CPR_BUS_IDLE: begin
                    if (cs_act) begin
                        bus_r <= CPR_BUS_ACCESS;
                    end
                end
                CPR_BUS_ACCESS: begin
                    if (acc_fire) begin
                        bus_r <= CPR_BUS_ACK;
                    end
                end
                CPR_BUS_ACK: begin
                    if (!cs_act) begin
                        bus_r <= CPR_BUS_IDLE;
                    end
                end
                default: begin
                    bus_r <= CPR_BUS_IDLE;
                end
            endcase
        end
    end

    // Data pins and size acknowledge, all from flops
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            data_r <= 32'h0000_0000;
            data_oe_r <= 1'b0;
            ack_hi_n_r <= 1'b1;
            ack_lo_n_r <= 1'b1;
        end else if (acc_fire) begin
            data_r <= rd ? rd_data : 32'h0000_0000;
            data_oe_r <= rd;
            // Word slots answer as a 16-bit port
            ack_hi_n_r <= 1'b0;
            ack_lo_n_r <= !is_long;
        end else if (bus_r == CPR_BUS_ACK && !cs_act) begin
            // Release the bus once select drops
            data_oe_r <= 1'b0;
            ack_hi_n_r <= 1'b1;
            ack_lo_n_r <= 1'b1;
        end
    end

    // Restore register: echo on valid, illegal code otherwise
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            restore_r <= `CPR_FMT_NULL;
        end else if (wr_restore) begin
            // Check type and version before restoring
            restore_r <= fmt_valid ? wdata[31:16] : `CPR_FMT_ILLEGAL;
        end
    end

    // Context phase: reset, idle, or frame load in progress
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            phase_r <= CPR_PH_RESET;
        end else if (wr_restore) begin
            // Null frame returns to default state
            if (fmt_valid && fmt_null) begin
                phase_r <= CPR_PH_RESET;
            end else if (fmt_valid) begin
                phase_r <= (fmt_words == 8'h00) ? CPR_PH_IDLE : CPR_PH_LOAD;
            end else begin
                phase_r <= CPR_PH_IDLE;
            end
        end else if (abort) begin
            // Control write ends any open load
            if (phase_r == CPR_PH_LOAD) begin
                phase_r <= CPR_PH_IDLE;
            end
        end else if (phase_r == CPR_PH_LOAD && loaded_r == expected_r) begin
            phase_r <= CPR_PH_IDLE;
        end else if (acc_fire && !rd && phase_r == CPR_PH_RESET
            && (sel[4:1] == `CPR_OFF_COMMAND >> 1 || sel[4:1] == `CPR_OFF_CONDITION >> 1)) begin
            // An instruction leaves the reset phase
            phase_r <= CPR_PH_IDLE;
        end
    end

    // Frame word bookkeeping
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            expected_r <= 8'h00;
            pushed_r <= 8'h00;
        end else if (abort) begin
            // Drop counts of the abandoned frame
            expected_r <= (wr_restore && fmt_valid) ? fmt_words : 8'h00;
            pushed_r <= 8'h00;
        end else if (push_want && fifo_in_ready) begin
            pushed_r <= pushed_r + 8'h01;
        end
    end

    // Loader pacing: one frame word per gap, stalls the FIFO between
    always_ff @(posedge clock_i) begin
        if (rst_i || abort) begin
            gap_r <= 4'h0;
            loaded_r <= 8'h00;
        end else if (fifo_out_valid && fifo_out_ready) begin
            gap_r <= `CPR_LOAD_GAP - 4'h1;
            loaded_r <= loaded_r + 8'h01;
        end else if (gap_r != 4'h0) begin
            gap_r <= gap_r - 4'h1;
        end
    end

    assign fifo_out_ready = (gap_r == 4'h0);

    // Frame words between bus and internal loader
    cpr_fifo #(
        .WIDTH(`CPR_DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .flush_i(abort),
        .in_valid_i(push_want),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wdata),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // Status outputs registered
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            null_state_o <= 1'b1;
            restore_busy_o <= 1'b0;
            frame_words_o <= 8'h00;
        end else begin
            null_state_o <= (phase_r == CPR_PH_RESET);
            restore_busy_o <= (phase_r == CPR_PH_LOAD);
            frame_words_o <= loaded_r;
        end
    end

    assign data_o = data_r;
    assign data_oe_o = data_oe_r;
    assign size_ack_high_n_o = ack_hi_n_r;
    assign size_ack_low_n_o = ack_lo_n_r;

    // Checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    a_restore_echo: assert property (wr_restore && fmt_valid |=> restore_r == $past(wdata[31:16]))
        else $error("restore echo wrong");
    a_restore_illegal: assert property (wr_restore && !fmt_valid |=> restore_r == `CPR_FMT_ILLEGAL)
        else $error("illegal code missing");
    a_restore_abort: assert property (wr_restore |=> pushed_r == 8'h00 && loaded_r == 8'h00)
        else $error("abort left frame state");
    a_null_defaults: assert property (wr_restore && fmt_valid && fmt_null |=> ##1 null_state_o)
        else $error("null frame not default");
    a_resp_clean: assert property (acc_fire && rd && sel == `CPR_OFF_RESPONSE
        |=> data_o[31:16] == `CPR_RESP_NULL && data_oe_o)
        else $error("response not clean");
    a_word_ack: assert property (acc_fire && !is_long
        |=> !size_ack_high_n_o && size_ack_low_n_o)
        else $error("word ack sizing wrong");
    a_unused_ones: assert property (acc_fire && rd && (sel == `CPR_OFF_OPWORD
        || sel[4:2] == `CPR_OFF_OPNDPTR >> 2) |=> data_o == `CPR_ALL_ONES)
        else $error("unused slot not ones");
    a_select_release: assert property (bus_r == CPR_BUS_ACK && !cs_act
        |=> size_ack_high_n_o && !data_oe_o ##1 bus_r == CPR_BUS_IDLE)
        else $error("bus not released");

    c_valid_restore: cover property (wr_restore && fmt_valid && !fmt_null);
    c_illegal_restore: cover property (wr_restore && !fmt_valid);
    c_load_done: cover property (phase_r == CPR_PH_LOAD ##1 phase_r == CPR_PH_IDLE);
    c_fifo_stall: cover property (push_want && !fifo_in_ready);
endmodule
`default_nettype wire

// ==== verif/cpr_host_model.sv ====
// Host processor model: CPU-space select decode and coprocessor bus cycles
`timescale 1ns/10ps
`default_nettype none
module cpr_host_model #(
    parameter logic [2:0] CP_NUM = 3'h1
) (
    input wire logic clock_i,
    input wire logic size_ack_high_n_i,
    input wire logic size_ack_low_n_i,
    input wire logic [31:0] bus_i,
    output logic cs_n_o,
    output logic rw_o,
    output logic [4:0] addr_o,
    output logic [31:0] data_o
);
    // Every coprocessor cycle runs in CPU space
    logic [2:0] fc_r = 3'h7;

    // Idle bus at time zero
    initial begin
        cs_n_o = 1'b1;
        rw_o = 1'b1;
        addr_o = 5'h00;
        data_o = 32'h0000_0000;
    end

    // One bus cycle: request held until the edge that samples the ack
    task automatic acc(input logic rd, input logic [31:0] adr, input logic [31:0] wd,
                       output logic [31:0] q, output logic lo);
        int n;
        q = 32'hFFFF_FFFF;
        lo = 1'bx;
        // select on space, type, number only
        if (fc_r == 3'h7 && adr[19:16] == 4'h2 && adr[15:13] == CP_NUM) begin
            @(negedge clock_i);
            rw_o = rd;
            addr_o = adr[4:0];
            // Released data shows the inverse; a read inverts it back to the last cycle's data
            data_o = rd ? ~data_o : wd;
            cs_n_o = 1'b0;
            n = 0;
            do begin
                @(posedge clock_i);
                n++;
            end while (size_ack_high_n_i !== 1'b0 && n < 20);
            q = (n < 20) ? bus_i : 32'hxxxx_xxxx;
            lo = size_ack_low_n_i;
            @(negedge clock_i);
            cs_n_o = 1'b1;
            data_o = ~data_o;
            n = 0;
            while (size_ack_high_n_i !== 1'b1 && n < 20) begin
                @(negedge clock_i);
                n++;
            end
            // Select stays high at least three cycles between cycles
            repeat (3) @(negedge clock_i);
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/tb_coproc_state_restore_port.sv ====
// Self-checking bench for the coprocessor state-restore port
`timescale 1ns/10ps
`default_nettype none
`include "cpr_defs.svh"
module tb_coproc_state_restore_port;
    localparam logic [2:0] CP = 3'h1; // Assigned coprocessor number
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, rw, ack_hi_n, ack_lo_n, oe, null_st, busy;
    logic [4:0] addr;
    logic [31:0] hdata, dout;
    logic [7:0] fw;
    wire logic [31:0] bus;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    // Wire level: device drives when enabled, else host
    assign bus = (oe === 1'b1) ? dout : hdata;

    // 10 MHz clock
    always #50 clock_i = ~clock_i;

    cpr_port i_cpr_port (.clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n), .rw_i(rw),
        .addr_i(addr), .data_i(bus), .data_o(dout), .data_oe_o(oe),
        .size_ack_high_n_o(ack_hi_n), .size_ack_low_n_o(ack_lo_n),
        .null_state_o(null_st), .restore_busy_o(busy), .frame_words_o(fw));

    cpr_host_model #(.CP_NUM(CP)) i_cpr_host_model (.clock_i(clock_i),
        .size_ack_high_n_i(ack_hi_n), .size_ack_low_n_i(ack_lo_n), .bus_i(bus),
        .cs_n_o(cs_n), .rw_o(rw), .addr_o(addr), .data_o(hdata));

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard, far above the expected run length
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // Upper address bits carry junk on purpose
    task automatic bus_rd(input logic [4:0] sel, output logic [31:0] q, output logic lo);
        i_cpr_host_model.acc(1'b1, {12'hA5C, 4'h2, CP, 8'h00, sel}, 32'h0, q, lo);
    endtask

    task automatic bus_wr(input logic [4:0] sel, input logic [31:0] wd);
        logic [31:0] q;
        logic lo;
        i_cpr_host_model.acc(1'b0, {12'h3C1, 4'h2, CP, 8'h00, sel}, wd, q, lo);
    endtask

    // Write a format word and return its read-back
    task automatic fmt(input logic [15:0] w, output logic [31:0] q);
        logic lo;
        bus_wr(`CPR_OFF_RESTORE, {w, 16'hFFFF});
        bus_rd(`CPR_OFF_RESTORE, q, lo);
    endtask

    // Frame long words in ascending order; pointer moves only at the end
    task automatic send(input int n);
        int ptr;
        ptr = 0;
        // one long word per access, lowest first
        for (int i = 0; i < n; i++) bus_wr(`CPR_OFF_OPERAND, 32'hC0DE_0000 + ptr + i);
        ptr = ptr + n;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clock_i);
            n++;
        end
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic lo;
        chk("null_state", 1, null_st);
        chk("busy", 0, busy);
        chk("oe", 0, oe);
        chk("frame_words", 0, fw);
        bus_rd(`CPR_OFF_SAVE, q, lo);
        chk("save_reset", {`CPR_FMT_NULL, 16'hFFFF}, q);
        $display("test reset done");
    endtask

    // Eight slots of the map read once (not control, save, restore or reserved), width taken from the ack pair
    task automatic t_map();
        logic [4:0] sel [8] = '{5'h00, 5'h08, 5'h0A, 5'h0E, 5'h10, 5'h14, 5'h18, 5'h1C};
        logic [31:0] ev [8] = '{32'h0000_FFFF, '1, '1, '1, '1, 32'h0000_FFFF, '1, '1};
        logic el [8] = '{1, 1, 1, 1, 0, 0, 0, 0};
        logic [31:0] q;
        logic lo;
        bus_wr(5'h08, 32'h1234_5678);
        bus_wr(5'h1C, 32'h8765_4321);
        for (int i = 0; i < 8; i++) begin
            bus_rd(sel[i], q, lo);
            chk("map_data", ev[i], q);
            chk("map_low_ack", el[i], lo);
        end
        chk("oe_released", 0, oe);
        // Command write leaves the reset phase
        bus_wr(`CPR_OFF_COMMAND, 32'h0000_FFFF);
        bus_rd(`CPR_OFF_SAVE, q, lo);
        chk("save_after_cmd", {`CPR_VERSION, `CPR_IDLE_SIZE, 16'hFFFF}, q);
        chk("null_after_cmd", 0, null_st);
        $display("test map done");
    endtask

    task automatic t_idle_restore();
        logic [31:0] q;
        logic lo;
        fmt({`CPR_VERSION, `CPR_IDLE_SIZE}, q);
        chk("echo", {`CPR_VERSION, `CPR_IDLE_SIZE, 16'hFFFF}, q);
        chk("busy_on", 1, busy);
        send(`CPR_IDLE_SIZE / 4);
        wait_idle();
        chk("busy_off", 0, busy);
        chk("frame_words", `CPR_IDLE_SIZE / 4, fw);
        chk("null_off", 0, null_st);
        bus_rd(`CPR_OFF_SAVE, q, lo);
        chk("save_idle", {`CPR_VERSION, `CPR_IDLE_SIZE, 16'hFFFF}, q);
        $display("test idle restore done");
    endtask

    task automatic t_bad_fmt();
        logic [15:0] bad [3] = '{16'h1E18, 16'h1F99, 16'h0218};
        logic [31:0] q;
        for (int i = 0; i < 3; i++) begin
            fmt(bad[i], q);
            chk("illegal", {`CPR_FMT_ILLEGAL, 16'hFFFF}, q);
            // no frame data follows an illegal read-back
            chk("no_load", 0, busy);
        end
        $display("test bad format done");
    endtask

    task automatic t_abort();
        logic [31:0] q;
        logic lo;
        fmt({`CPR_VERSION, `CPR_BUSY_SIZE}, q);
        chk("echo_busy", {`CPR_VERSION, `CPR_BUSY_SIZE, 16'hFFFF}, q);
        send(2);
        fmt({`CPR_VERSION, `CPR_IDLE_SIZE}, q);
        chk("reload", {`CPR_VERSION, `CPR_IDLE_SIZE, 16'hFFFF}, q);
        chk("busy_reload", 1, busy);
        // Save word while a frame is still owed
        bus_rd(`CPR_OFF_SAVE, q, lo);
        chk("save_load", {`CPR_FMT_ILLEGAL, 16'hFFFF}, q);
        bus_wr(`CPR_OFF_CONTROL, 32'h0000_FFFF);
        repeat (4) @(negedge clock_i);
        chk("abort", 0, busy);
        $display("test abort done");
    endtask

    task automatic t_null();
        logic [31:0] q;
        logic lo;
        fmt(`CPR_FMT_NULL, q);
        chk("echo_null", {`CPR_FMT_NULL, 16'hFFFF}, q);
        chk("null_back", 1, null_st);
        bus_rd(`CPR_OFF_SAVE, q, lo);
        chk("save_null", {`CPR_FMT_NULL, 16'hFFFF}, q);
        $display("test null restore done");
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clock_i);
        @(negedge clock_i);
        rst_i = 1'b0;
        t_reset();
        t_map();
        t_idle_restore();
        t_bad_fmt();
        t_abort();
        t_null();
        summarize();
    end
endmodule
`default_nettype wire
